// ===== fsr_status_ctrl.sv
/*
 * Status register, write gating and two-step software reset of a
 * serial multi-line flash. Link logic runs on the serial clock; the
 * register bank runs on clk_i. Assumes the array engine follows
 * op_start_o and that the host stops its clock outside frames.
 */
// Notes on behaviour
// - Reset-arm 0x66 then reset 0x99, single or four-line; 0x00 no-op.
// - Reset counts only straight after reset-arm; anything between cancels.
// - Identification read: address 00h gives maker code first, 01h device; answered only in single-line mode, not four-line.
// - Address phase is three bytes, four when four-byte addressing is on.
// - Bit 0 busy flag high during program, erase or status write.
// - Bit 1 write latch set by write-enable command.
// - Program or erase with write latch clear is ignored.
// - Write latch clears when a program or erase finishes.
// - Program or erase into protected region ignored; write latch cleared.
// - Bits 5..2 protect level, reset zero, changed only by status write.
// - Chip erase runs only with all protect level bits zero.
// - Bit 6 four-line enable, default zero.
// - Four-line enable off: quad commands ignored, pin 2 is write protect.
// - Four-line enable on disables high-performance mode and reset pin.
// - Status lock set with protect pin low rejects status write.
// - Status lock defaults to zero, status writes allowed.
`timescale 1ns/1ps
module fsr_status_ctrl
    import fsr_pkg::*;
#(
    parameter int unsigned OP_CYCLES = 64,
    parameter int unsigned SW_CYCLES = 32,
    parameter int          TMR_W     = 16,
    parameter logic [7:0]  MFR_CODE  = 8'hA5,  // Arbitrary value
    parameter logic [7:0]  DEV_CODE  = 8'h5A   // Arbitrary value
) (
    // Core clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Serial link
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  dl_i,
    output logic      [3:0]  dl_o,
    output logic      [3:0]  dl_oe_o,
    // Configuration from same-clock logic
    input  wire logic        four_byte_addr_i,
    // Status and pin functions
    output logic      [7:0]  status_flags_o,
    output logic             four_line_enable_o,
    output logic             high_perf_allow_o,
    output logic             hw_reset_pin_en_o,
    // Array engine requests
    output logic             soft_reset_o,
    output logic             op_start_o,
    output logic      [7:0]  op_kind_o,
    output logic      [31:0] op_addr_o
);
    localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

    logic [1:0]       rsync_reg;
    logic             rst_n;
    logic             link_rst_n;
    // Link domain
    logic [2:0]       bit_cnt_reg;
    logic [2:0]       byte_cnt_reg;
    logic [7:0]       shift_reg;
    logic [7:0]       opc_reg;
    logic [7:0]       tx_byte_reg;
    logic             tx_on_reg;
    logic             id_sel_reg;
    logic [7:0]       byte_hold_reg;
    logic             first_hold_reg;
    logic             byte_tgl_reg;
    logic             rst_tgl_reg;
    logic             arm_reg;
    logic             qmode_reg;
    logic             ack_tgl_reg;
    logic [7:0]       shadow_reg;
    logic [1:0]       lsync;
    logic             rx_done;
    logic [7:0]       rx_byte;
    logic [7:0]       op_now;
    logic             id_next;
    // Core domain
    logic [4:0]       csync;
    logic             cs_d3_reg;
    logic             btgl_d_reg;
    logic             rtgl_d_reg;
    logic [7:0]       op_reg;
    logic [2:0]       nb_reg;
    logic [7:0]       data_reg;
    logic [31:0]      addr_reg;
    fsr_state_e       st_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic             pend_sw_reg;
    logic             wel_reg;
    logic             qe_reg;
    logic             lock_reg;
    logic [3:0]       prot_reg;
    logic [7:0]       hold_reg;
    logic             req_reg;
    logic             byte_ev;
    logic             rst_ev;
    logic             exec;
    logic             ready;
    logic             is_pe;
    logic             is_ce;
    logic             addr_ok;
    logic [2:0]       nb_addr;
    logic             hit;
    logic             hw_lock;
    logic             go_pe;
    logic             go_ce;
    logic             go_sw;
    logic             deny;
    logic             done;
    logic [7:0]       status;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsync_reg <= 2'b00;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end
    assign rst_n = rsync_reg[1];

    // Deselect clears the framing state without any clock edge
    assign link_rst_n = rst_n & ~cs_n_i;

    fsr_sync #(.W(2)) u_lsync (
        .clk_i   (sclk_i),
        .rst_n_i (rst_n),
        .d_i     ({req_reg, qe_reg}),
        .q_o     (lsync)
    );

    assign rx_done = bit_cnt_reg == (qmode_reg ? LAST_BIT_4 : LAST_BIT_1);
    assign rx_byte = qmode_reg ? {shift_reg[3:0], dl_i}
                               : {shift_reg[6:0], dl_i[0]};
    assign op_now  = (byte_cnt_reg == 3'h0) ? rx_byte : opc_reg;
    assign id_next = (byte_cnt_reg == ID_ADDR_IDX) ? rx_byte[0] : ~id_sel_reg;

    // Framing and reply selection
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_reg    <= 8'h00;
            opc_reg      <= OP_NOP;
            tx_byte_reg  <= 8'h00;
            tx_on_reg    <= 1'b0;
            id_sel_reg   <= 1'b0;
        end else begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= rx_done ? 3'h0 : bit_cnt_reg + 3'h1;
            if (rx_done) begin
                if (byte_cnt_reg != NB_MAX) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
                if (byte_cnt_reg == 3'h0) begin
                    opc_reg <= rx_byte;
                end
                if (op_now == OP_STAT_RD) begin
                    tx_on_reg   <= 1'b1;
                    tx_byte_reg <= shadow_reg;
                end else if (opc_reg == OP_ID_READ &&
                             byte_cnt_reg >= ID_ADDR_IDX &&
                             !qmode_reg) begin
                    tx_on_reg   <= 1'b1;
                    id_sel_reg  <= id_next;
                    tx_byte_reg <= id_next ? DEV_CODE : MFR_CODE;
                end
            end
        end
    end

    // Reply bits change on the falling edge, host samples on the rising
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            dl_o    <= 4'h0;
            dl_oe_o <= 4'h0;
        end else if (!tx_on_reg) begin
            dl_o    <= 4'h0;
            dl_oe_o <= 4'h0;
        end else if (qmode_reg) begin
            dl_oe_o <= OE_QUAD;
            dl_o    <= (bit_cnt_reg == 3'h0) ? tx_byte_reg[7:4]
                                             : tx_byte_reg[3:0];
        end else begin
            dl_oe_o <= OE_SINGLE;
            dl_o    <= {2'b00, tx_byte_reg[LAST_BIT_1 - bit_cnt_reg], 1'b0};
        end
    end

    // Frame-spanning link state; survives deselect
    always_ff @(posedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_hold_reg  <= 8'h00;
            first_hold_reg <= 1'b0;
            byte_tgl_reg   <= 1'b0;
            rst_tgl_reg    <= 1'b0;
            arm_reg        <= 1'b0;
            qmode_reg      <= 1'b0;
        end else if (rx_done && !cs_n_i) begin
            byte_hold_reg  <= rx_byte;
            first_hold_reg <= byte_cnt_reg == 3'h0;
            byte_tgl_reg   <= ~byte_tgl_reg;
            if (byte_cnt_reg == 3'h0) begin
                arm_reg <= rx_byte == OP_RST_ARM;
                if (rx_byte == OP_RST && arm_reg) begin
                    rst_tgl_reg <= ~rst_tgl_reg;
                    qmode_reg   <= 1'b0;
                end else if (rx_byte == OP_QCMD_ENTER && lsync[0]) begin
                    qmode_reg <= 1'b1;
                end else if (rx_byte == OP_QCMD_EXIT) begin
                    qmode_reg <= 1'b0;
                end
            end
        end
    end

    // Status word handover: hold stays put until acknowledged
    always_ff @(posedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_tgl_reg <= 1'b0;
            shadow_reg  <= 8'h00;
        end else if (lsync[1] != ack_tgl_reg) begin
            ack_tgl_reg <= lsync[1];
            shadow_reg  <= hold_reg;
        end
    end

    fsr_sync #(.W(5)) u_csync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     ({cs_n_i, dl_i[2], byte_tgl_reg, rst_tgl_reg, ack_tgl_reg}),
        .q_o     (csync)
    );

    // Extra cs stage lets the last byte event land before frame end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_d3_reg  <= 1'b0;
            btgl_d_reg <= 1'b0;
            rtgl_d_reg <= 1'b0;
        end else begin
            cs_d3_reg  <= csync[4];
            btgl_d_reg <= csync[2];
            rtgl_d_reg <= csync[1];
        end
    end
    assign byte_ev = csync[2] ^ btgl_d_reg;
    assign rst_ev  = csync[1] ^ rtgl_d_reg;
    assign exec    = csync[4] && !cs_d3_reg && nb_reg != 3'h0;

    // Command collection
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            op_reg   <= OP_NOP;
            nb_reg   <= 3'h0;
            data_reg <= 8'h00;
            addr_reg <= 32'h0000_0000;
        end else if (exec) begin
            nb_reg <= 3'h0;
        end else if (byte_ev && first_hold_reg) begin
            op_reg   <= byte_hold_reg;
            nb_reg   <= 3'h1;
            addr_reg <= 32'h0000_0000;
        end else if (byte_ev) begin
            nb_reg <= (nb_reg == NB_MAX) ? NB_MAX : nb_reg + 3'h1;
            // Data bytes past the address phase must not shift it out
            if (nb_reg < nb_addr) begin
                addr_reg <= {addr_reg[23:0], byte_hold_reg};
            end
            if (nb_reg == 3'h1) begin
                data_reg <= byte_hold_reg;
            end
        end
    end

    // Unknown opcodes match no decode and fall through unexecuted.
    assign ready   = st_reg == ST_READY;
    assign is_pe   = op_reg == OP_PAGE_PROG || op_reg == OP_SECT_ERASE ||
                     op_reg == OP_HALF_BLK || op_reg == OP_BLK_ERASE;
    assign is_ce   = op_reg == OP_CHIP_ERASE;
    assign nb_addr = four_byte_addr_i ? NB_ADDR4 : NB_ADDR3;
    assign addr_ok = nb_reg >= nb_addr;
    assign hit     = fsr_prot_hit(addr_reg, prot_reg);
    assign hw_lock = lock_reg && !qe_reg && !csync[3];
    assign go_pe   = exec && ready && wel_reg && is_pe && addr_ok && !hit;
    assign go_ce   = exec && ready && wel_reg && is_ce &&
                     prot_reg == PROT_NONE;
    assign go_sw   = exec && ready && wel_reg && op_reg == OP_STAT_WR &&
                     nb_reg >= NB_STAT_WR && !hw_lock;
    assign deny    = exec && ready && wel_reg &&
                     ((is_pe && addr_ok && hit) ||
                      (is_ce && prot_reg != PROT_NONE));
    assign done    = st_reg == ST_BUSY && tmr_reg == TMR_ONE && !rst_ev;

    // Busy sequencing
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= ST_READY;
            tmr_reg     <= '0;
            pend_sw_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_READY: begin
                    if (go_pe || go_ce || go_sw) begin
                        st_reg      <= ST_BUSY;
                        pend_sw_reg <= go_sw;
                        tmr_reg     <= go_sw ? TMR_W'(SW_CYCLES)
                                             : TMR_W'(OP_CYCLES);
                    end
                end
                ST_BUSY: begin
                    tmr_reg <= tmr_reg - TMR_ONE;
                    if (rst_ev || tmr_reg == TMR_ONE) begin
                        st_reg <= ST_READY;
                    end
                end
                default: begin
                    st_reg <= ST_READY;
                end
            endcase
        end
    end

    // Write latch
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wel_reg <= 1'b0;
        end else if (rst_ev || done || deny) begin
            wel_reg <= 1'b0;
        end else if (exec && ready && op_reg == OP_WR_EN) begin
            wel_reg <= 1'b1;
        end else if (exec && ready && op_reg == OP_WR_DIS) begin
            wel_reg <= 1'b0;
        end
    end

    // Retained bits; only a finished status write alters them
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= 1'b0;
            qe_reg   <= 1'b0;
            prot_reg <= PROT_NONE;
        end else if (done && pend_sw_reg) begin
            lock_reg <= data_reg[BIT_LOCK];
            qe_reg   <= data_reg[BIT_QE];
            prot_reg <= data_reg[BIT_PROT_HI:BIT_PROT_LO];
        end
    end

    assign status = {lock_reg, qe_reg, prot_reg, wel_reg,
                     st_reg == ST_BUSY};

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 8'h00;
            req_reg  <= 1'b0;
        end else if (csync[0] == req_reg && hold_reg != status) begin
            hold_reg <= status;
            req_reg  <= ~req_reg;
        end
    end

    // Array requests
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            op_start_o   <= 1'b0;
            op_kind_o    <= OP_NOP;
            op_addr_o    <= 32'h0000_0000;
            soft_reset_o <= 1'b0;
        end else begin
            op_start_o   <= go_pe || go_ce;
            soft_reset_o <= rst_ev;
            if (go_pe || go_ce) begin
                op_kind_o <= op_reg;
                op_addr_o <= addr_reg;
            end
        end
    end

    assign status_flags_o     = status;
    assign four_line_enable_o = qe_reg;
    assign high_perf_allow_o  = ~qe_reg;
    assign hw_reset_pin_en_o  = ~qe_reg;

    sequence s_start;
        op_start_o;
    endsequence
    sequence s_done;
        status[BIT_BUSY] ##1 !status[BIT_BUSY];
    endsequence

    AST_BUSY_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_start |-> status[BIT_BUSY] [*2])
        else $error("busy not held after start");
    AST_WEL_ON_DONE: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_done |-> !wel_reg)
        else $error("write latch left set after operation");
    AST_NEED_WEL: assert property (@(posedge clk_i) disable iff (!rst_n)
        op_start_o |-> $past(wel_reg))
        else $error("operation started without write latch");
    AST_CE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
        op_start_o && op_kind_o == OP_CHIP_ERASE |->
            $past(prot_reg) == PROT_NONE)
        else $error("chip erase with protection set");
    AST_PROT_DENY: assert property (@(posedge clk_i) disable iff (!rst_n)
        deny |=> !wel_reg && !status[BIT_BUSY] && !op_start_o)
        else $error("protected operation not refused");
    AST_HW_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n)
        exec && ready && op_reg == OP_STAT_WR && hw_lock |=> ready)
        else $error("status write accepted while locked");
    AST_PROT_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n)
        !$stable(status[BIT_LOCK:BIT_PROT_LO]) |-> $past(pend_sw_reg) &&
            $fell(status[BIT_BUSY]))
        else $error("retained bits changed outside status write");
    AST_WRITE_ENABLE_CMD: assert property (@(posedge clk_i) disable iff (!rst_n)
        exec && ready && op_reg == OP_WR_EN |=> wel_reg)
        else $error("write enable did not set latch");
    AST_QE_PINS: assert property (@(posedge clk_i) disable iff (!rst_n)
        four_line_enable_o |-> !high_perf_allow_o && !hw_reset_pin_en_o)
        else $error("four-line enable left pin functions on");
    AST_ARM_FIRST: assert property (@(posedge sclk_i) disable iff (!rst_n)
        $changed(rst_tgl_reg) |-> $past(arm_reg))
        else $error("reset taken without reset-arm");

endmodule : fsr_status_ctrl

// ===== fsr_pkg.sv
/*
 * Shared constants for the flash status and reset logic: opcodes,
 * status bit positions, protection geometry and state encoding.
 * Assumes the host speaks the serial command set listed here.
 */
package fsr_pkg;

    // Reset, no-operation and identification opcodes
    localparam logic [7:0] OP_NOP        = 8'h00;
    localparam logic [7:0] OP_RST_ARM    = 8'h66;
    localparam logic [7:0] OP_RST        = 8'h99;
    localparam logic [7:0] OP_ID_READ    = 8'h90;
    // Write control, status, array and four-line mode opcodes
    localparam logic [7:0] OP_WR_EN      = 8'h06;
    localparam logic [7:0] OP_WR_DIS     = 8'h04;
    localparam logic [7:0] OP_STAT_RD    = 8'h05;
    localparam logic [7:0] OP_STAT_WR    = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLK   = 8'h52;
    localparam logic [7:0] OP_BLK_ERASE  = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] OP_QCMD_ENTER = 8'h35;
    localparam logic [7:0] OP_QCMD_EXIT  = 8'hF5;

    // Status register layout
    localparam int         BIT_BUSY    = 0;
    localparam int         BIT_WLATCH  = 1;
    localparam int         BIT_PROT_LO = 2;
    localparam int         BIT_PROT_HI = 5;
    localparam int         BIT_QE      = 6;
    localparam int         BIT_LOCK    = 7;
    localparam logic [3:0] PROT_NONE   = 4'h0;

    // Serial framing
    localparam logic [2:0] LAST_BIT_1  = 3'h7;
    localparam logic [2:0] LAST_BIT_4  = 3'h1;
    localparam logic [2:0] ID_ADDR_IDX = 3'h3;
    localparam logic [2:0] NB_MAX      = 3'h7;
    localparam logic [2:0] NB_STAT_WR  = 3'h2;
    localparam logic [2:0] NB_ADDR3    = 3'h4;
    localparam logic [2:0] NB_ADDR4    = 3'h5;
    localparam logic [3:0] OE_QUAD     = 4'hF;
    localparam logic [3:0] OE_SINGLE   = 4'h2;

    // Protection geometry: 64 KiB blocks counted from the top
    localparam int          BLK_LSB    = 16;
    localparam int          BLK_MSB    = 25;
    localparam logic [15:0] LAST_BLOCK = 16'h03FF;

    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_BUSY  = 2'b10
    } fsr_state_e;

    function automatic logic fsr_prot_hit(input logic [31:0] a,
                                          input logic [3:0]  lvl);
        logic [15:0] from_top;
        logic [15:0] span;
        from_top = LAST_BLOCK - 16'(a[BLK_MSB:BLK_LSB]);
        span     = (lvl == PROT_NONE) ? 16'h0000
                 : 16'(32'h0000_0001 << (lvl - 4'h1));
        return from_top < span;
    endfunction : fsr_prot_hit

endpackage : fsr_pkg

// ===== fsr_sync.sv
/*
 * Two-flop level synchroniser, W bits wide.
 * Assumes each bit is a slow level or a toggle, never a coded word.
 */
`timescale 1ns/1ps
module fsr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            q_o    <= '0;
        end else begin
            s1_reg <= d_i;
            q_o    <= s1_reg;
        end
    end
endmodule : fsr_sync

// ===== fsr_host_model.sv
/*
 * Host serial controller model: frames bytes MSB first on one line, or on four in qframe.
 * Assumes the device replies on line 1, or on all four lines in qframe, after the last byte sent.
 */
`timescale 1ns/1ps
module fsr_host_model (
    // Link to the device
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic [3:0] dl_o,
    input  wire logic [3:0] dl_i
);
    logic wp_n;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        dl_o   = 4'hD;
        wp_n   = 1'b1;
    end

    // Only listed opcodes are ever sent by callers
    task automatic frame(input logic [7:0] tx[$], input int nrx,
                         output logic [15:0] rx);
        rx = 16'h0000;
        dl_o[2] = wp_n;
        cs_n_o = 1'b0;
        #100;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                dl_o[0] = tx[i][b];
                #80 sclk_o = 1'b1;
                #80 sclk_o = 1'b0;
            end
        end
        for (int b = 0; b < nrx; b++) begin
            // Released data line toggles so it never looks held
            dl_o[0] = ~dl_o[0];
            #80 sclk_o = 1'b1;
            rx = {rx[14:0], dl_i[1]};
            #80 sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        dl_o[0] = ~dl_o[0];
        #300;
    endtask : frame

    // Four-line frame: one nibble per clock, upper nibble first
    task automatic qframe(input logic [7:0] tx[$], input int nrx,
                          output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o = 1'b0;
        #100;
        foreach (tx[i]) begin
            for (int n = 1; n >= 0; n--) begin
                dl_o = tx[i][n*4 +: 4];
                #80 sclk_o = 1'b1;
                #80 sclk_o = 1'b0;
            end
        end
        for (int n = 0; n < nrx; n++) begin
            dl_o = ~dl_o;
            #80 sclk_o = 1'b1;
            rx = {rx[11:0], dl_i};
            #80 sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        dl_o = 4'hD;
        #300;
    endtask : qframe
endmodule : fsr_host_model

// ===== flash_status_and_reset_logic_bench.sv
/*
 * Self-checking bench for the status and reset logic.
 * Assumes the host model stops its clock between frames.
 */
`timescale 1ns/1ps
module flash_status_and_reset_logic_bench;
    import fsr_pkg::*;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        sclk, cs_n;
    logic [3:0]  dl_h, dl_d, oe;
    logic [7:0]  st, kind;
    logic [31:0] addr;
    logic        qe, hpa, hrp, srst, ost, fba = 1'b0;
    int          n_mismatch = 0, samples_checked = 0, n_srst = 0, n_ops = 0;

    always #12.5 clk_i = ~clk_i;
    // Pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge clk_i) begin
        n_srst += int'(srst === 1'b1);
        n_ops  += int'(ost === 1'b1);
    end

    // Released reply lines float high, so an idle line never reads as data
    fsr_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .dl_o(dl_h),
                         .dl_i(dl_d | ~oe));
    // Long busy times so a link status read fits inside them
    fsr_status_ctrl #(.OP_CYCLES(400), .SW_CYCLES(300),
        .MFR_CODE(8'h12), .DEV_CODE(8'h34)) // Arbitrary values
    dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .dl_i(dl_h), .dl_o(dl_d), .dl_oe_o(oe),
        .four_byte_addr_i(fba), .status_flags_o(st),
        .four_line_enable_o(qe), .high_perf_allow_o(hpa),
        .hw_reset_pin_en_o(hrp), .soft_reset_o(srst), .op_start_o(ost),
        .op_kind_o(kind), .op_addr_o(addr));

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", what, e, g);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] q[$]);
        logic [15:0] rx;
        host.frame(q, 0, rx);
        repeat (10) @(negedge clk_i);
    endtask : cmd

    // Second byte is used: the first may be one update stale
    task automatic rd_stat(output logic [7:0] s);
        logic [15:0] rx;
        host.frame('{OP_STAT_RD}, 16, rx);
        s = rx[7:0];
    endtask : rd_stat

    // Busy must fall before write latch is judged
    task automatic wait_idle;
        int k;
        for (k = 0; k < 1000 && st[0] !== 1'b0; k++) @(negedge clk_i);
        if (k == 1000) begin
            chk("busy wait", 0, 1);
            tally_and_finish;
        end
    endtask : wait_idle

    task automatic wr_stat(input logic [7:0] v);
        cmd('{OP_WR_EN});
        cmd('{OP_STAT_WR, v});
        wait_idle;
    endtask : wr_stat

    task automatic t_reset;
        logic [7:0] s;
        chk("status", 0, st);
        chk("hpm/rst pin", 3, {hpa, hrp});
        cmd('{OP_QCMD_ENTER});
        rd_stat(s);
        chk("link status", 0, s);
        $display("test reset done");
    endtask : t_reset

    task automatic t_id;
        logic [15:0] rx;
        host.frame('{OP_ID_READ, 8'h00, 8'h00, 8'h00}, 16, rx);
        chk("id 00", 32'h0000_1234, rx);
        host.frame('{OP_ID_READ, 8'h00, 8'h00, 8'h01}, 16, rx);
        chk("id 01", 32'h0000_3412, rx);
        $display("test id done");
    endtask : t_id

    task automatic t_prog;
        logic [7:0] s;
        cmd('{OP_PAGE_PROG, 8'h00, 8'h10, 8'h00});
        chk("ops no latch", 0, n_ops);
        cmd('{OP_WR_EN});
        chk("latch", 2, st);
        cmd('{OP_PAGE_PROG, 8'h01, 8'h23, 8'h45, 8'hAA});
        chk("ops", 1, n_ops);
        chk("kind", OP_PAGE_PROG, kind);
        chk("addr", 32'h0001_2345, addr);
        rd_stat(s);
        chk("busy on link", 3, s);
        wait_idle;
        chk("done", 0, st);
        cmd('{OP_WR_EN});
        cmd('{OP_CHIP_ERASE});
        chk("chip erase ops", 2, n_ops);
        chk("chip erase kind", OP_CHIP_ERASE, kind);
        wait_idle;
        fba = 1'b1;
        cmd('{OP_WR_EN});
        cmd('{OP_SECT_ERASE, 8'h01, 8'h23, 8'h45, 8'h67});
        chk("addr4", 32'h0123_4567, addr);
        wait_idle;
        fba = 1'b0;
        $display("test program done");
    endtask : t_prog

    task automatic t_rst;
        int n0;
        n0 = n_srst;
        cmd('{OP_WR_EN});
        cmd('{OP_SECT_ERASE, 8'h00, 8'h00, 8'h00});
        cmd('{OP_RST_ARM});
        cmd('{OP_RST});
        chk("soft reset", n0 + 1, n_srst);
        chk("aborted", 0, st);
        cmd('{OP_RST_ARM});
        cmd('{OP_NOP});
        cmd('{OP_RST});
        chk("cancelled", n0 + 1, n_srst);
        $display("test reset sequence done");
    endtask : t_rst

    task automatic t_prot;
        int n0;
        wr_stat(8'h3C);
        chk("protect", 32'h0000_003C, st);
        n0 = n_ops;
        cmd('{OP_WR_EN});
        cmd('{OP_CHIP_ERASE});
        chk("chip erase", n0, n_ops);
        chk("latch cleared", 32'h0000_003C, st);
        cmd('{OP_WR_EN});
        cmd('{OP_BLK_ERASE, 8'h03, 8'hFF, 8'h00});
        chk("block erase", n0, n_ops);
        chk("latch cleared", 32'h0000_003C, st);
        $display("test protect done");
    endtask : t_prot

    task automatic t_lock;
        wr_stat(8'h80);
        host.wp_n = 1'b0;
        cmd('{OP_WR_EN});
        cmd('{OP_STAT_WR, 8'h00});
        chk("locked", 32'h0000_0082, st);
        host.wp_n = 1'b1;
        cmd('{OP_STAT_WR, 8'h40});
        wait_idle;
        chk("quad", 32'h0000_0040, st);
        chk("pins", 4, {qe, hpa, hrp});
        $display("test lock done");
    endtask : t_lock

    task automatic t_quad;
        logic [15:0] rx;
        logic [7:0]  s;
        cmd('{OP_QCMD_ENTER});
        host.qframe('{OP_STAT_RD}, 4, rx);
        chk("four-line status", 32'h0000_0040, rx[7:0]);
        host.qframe('{OP_QCMD_EXIT}, 0, rx);
        rd_stat(s);
        chk("single after exit", 32'h0000_0040, s);
        $display("test four-line done");
    endtask : t_quad

    initial begin
        #1_000_000;
        chk("watchdog", 0, 1);
        tally_and_finish;
    end

    initial begin
        repeat (10) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        t_reset;
        t_id;
        t_prog;
        t_rst;
        t_prot;
        t_lock;
        t_quad;
        tally_and_finish;
    end
endmodule : flash_status_and_reset_logic_bench
